/* File: rtl/sysreg_bank_pkg.sv */
// Shared constants and carriers for the syndrome, hypervisor configuration and feature register bank
package sysreg_bank_pkg;

	// ****************************************
	// Register selects on the system-register port
	// ****************************************
	localparam logic [3:0] SEL_HYP_SYNDROME = 4'h0;
	localparam logic [3:0] SEL_TOP_SYNDROME = 4'h1;
	localparam logic [3:0] SEL_HYP_CONFIG = 4'h2;
	localparam logic [3:0] SEL_HYP_AUX_CONFIG = 4'h3;
	localparam logic [3:0] SEL_DEBUG_FEATURE_ZERO = 4'h4;
	localparam logic [3:0] SEL_DEBUG_FEATURE_ONE = 4'h5;
	localparam logic [3:0] SEL_AUX_FEATURE_ZERO = 4'h6;
	localparam logic [3:0] SEL_AUX_FEATURE_ONE = 4'h7;
	localparam logic [3:0] SEL_ISA_ATTRIBUTE_ZERO = 4'h8;

	// ****************************************
	// Exception levels
	// ****************************************
	localparam logic [1:0] LEVEL_KERNEL = 2'h1;
	localparam logic [1:0] LEVEL_HYP = 2'h2;
	localparam logic [1:0] LEVEL_TOP = 2'h3;

	// ****************************************
	// Syndrome field positions
	// ****************************************
	localparam int CLASS_LSB = 26;
	localparam int LENGTH_BIT = 25;
	localparam int SYND_VALID_BIT = 24;
	localparam int IMPL_SYND_BIT = 24;
	localparam int ERR_TYPE_LSB = 10;
	localparam int EXT_ABORT_BIT = 9;
	localparam logic [5:0] CLASS_UNKNOWN = 6'h00;
	localparam logic [5:0] CLASS_SYSERR = 6'h2f;
	localparam logic [2:0] ERR_TYPE_UNCONTAINABLE = 3'h0;
	localparam logic [2:0] ERR_TYPE_UNRECOVERABLE = 3'h1;

	// ****************************************
	// Hypervisor configuration fields
	// ****************************************
	localparam int CFG_FAST_IRQ_ROUTE = 3;
	localparam int CFG_IRQ_ROUTE = 4;
	localparam int CFG_ASYNC_ABORT_ROUTE = 5;
	localparam int CFG_ID_GROUP3_TRAP = 18;
	localparam int CFG_TRAP_GENERAL = 27;
	localparam int CFG_MISMATCH_NONCOHERENCY = 38;
	localparam logic [63:0] CFG_ZERO_MASK = 64'hffff_ff80_0000_8000;
	localparam logic [63:0] CFG_ONE_MASK = 64'h0000_0000_8000_0000;
	localparam logic [31:0] SYNDROME_RESET = 32'h0000_0000;
	localparam logic [63:0] CONFIG_RESET = 64'h0000_0000_8000_0000;

	// ****************************************
	// Hardwired feature values
	// ****************************************
	localparam logic [63:0] DEBUG_FEATURE_ZERO_VALUE = 64'h0000_0000_1030_5408;
	localparam logic [63:0] ISA_ATTRIBUTE_ZERO_VALUE = 64'h0000_0000_1021_0000;
	localparam logic [63:0] ZERO_FEATURE_VALUE = 64'h0000_0000_0000_0000;

	// ****************************************
	// Carriers
	// ****************************************
	typedef enum logic [2:0] {
		EXC_OTHER,
		EXC_DATA_ABORT,
		EXC_DATA_ABORT_NO_ISV,
		EXC_PHYS_SYSERR,
		EXC_VIRT_SYSERR,
		EXC_INSTR_ABORT,
		EXC_MISALIGNED,
		EXC_ILLEGAL_STATE
	} exc_kind_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [3:0] sel;
		logic [1:0] level;
		logic nonsecure;
		logic [63:0] wdata;
	} sysreg_req_t;

	typedef struct packed {
		logic valid;
		logic trap;
		logic [63:0] rdata;
	} sysreg_rsp_t;

	typedef struct packed {
		logic valid;
		logic to_top;
		exc_kind_t kind;
		logic [5:0] exc_class;
		logic length_32;
		logic detail_valid;
		logic uncontainable;
		logic [24:0] detail;
	} exc_report_t;

	typedef struct packed {
		logic route_kernel_to_hyp;
		logic kernel_translation_enable;
		logic fast_irq_route;
		logic irq_route;
		logic async_abort_route;
		logic virtual_irq_enable;
		logic impl_virtual_signal_enable;
		logic illegal_return;
	} routing_t;

endpackage

/* File: rtl/syndrome_hypconfig_feature_regs.sv */
// Syndrome, hypervisor configuration and hardwired feature register bank
// Notes on behaviour
// - Hypervisor syndrome: class, length flag, detail
// - Length flag: 0 short, 1 long instruction
// - Virtual system error copies virtual syndrome detail
// - Physical system error: architectural, typed, no abort
// - Synchronous data abort reports external abort zero
// - Without hypervisor level, hypervisor registers read zero
// - Writable fields have no defined reset value
// - Top syndrome: class, length, valid, detail
// - Top syndrome forces length flag for listed causes
// - Invalid syndrome drives detail field to zero
// - System error class carries implementation-specific detail
// - Configuration: high bits zero, bit 31 one
// - Trap general: kernel exceptions go to hypervisor
// - Trap general: routes forced, virtual interrupts off
// - Trap general: return to kernel is illegal
// - Trap general used live, never cached
// - Secure state treats trap general as zero
// - Group-3 trap bit traps non-secure kernel identification reads
// - Auxiliary and second debug registers read zero
// - Debug feature: breakpoint and watchpoint counts
// - Debug feature: monitor, trace, debug versions
// - Instruction attribute: multiply, atomic, checksum fields
`timescale 1ns/1ns
module syndrome_hypconfig_feature_regs
	import sysreg_bank_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hyp_level_present,
	input wire sysreg_bank_pkg::sysreg_req_t req,
	output sysreg_bank_pkg::sysreg_rsp_t rsp,
	input wire sysreg_bank_pkg::exc_report_t exc,
	input wire logic [24:0] virtual_syserr_syndrome,
	input wire logic nonsecure_state_bit,
	input wire logic kernel_translation_enable,
	input wire logic eret_to_kernel,
	output sysreg_bank_pkg::routing_t routing
);

	// ****************************************
	// Strap synchroniser
	// ****************************************
	logic hyp_meta_q;
	logic hyp_present_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hyp_meta_q <= 1'b0;
			hyp_present_q <= 1'b0;
		end else begin
			hyp_meta_q <= hyp_level_present;
			hyp_present_q <= hyp_meta_q;
		end
	end

	// ****************************************
	// Storage
	// ****************************************
	logic [31:0] hyp_exception_syndrome_q;
	logic [31:0] top_exception_syndrome_q;
	logic [63:0] hyp_configuration_q;
	logic [31:0] hyp_syndrome_d;
	logic [31:0] top_syndrome_d;
	logic [63:0] config_d;
	logic sw_write;
	logic hyp_write_ok;

	assign sw_write = req.valid & req.write;
	// Without the hypervisor level the hypervisor registers swallow writes
	assign hyp_write_ok = sw_write & hyp_present_q;

	// ****************************************
	// Syndrome capture
	// ****************************************
	logic [24:0] hyp_detail;
	logic [23:0] top_detail;
	logic top_long;

	always_comb begin
		hyp_detail = exc.detail;
		case (exc.kind)
			EXC_VIRT_SYSERR: begin
				hyp_detail = virtual_syserr_syndrome;
			end
			EXC_PHYS_SYSERR: begin
				hyp_detail[IMPL_SYND_BIT] = 1'b0;
				hyp_detail[ERR_TYPE_LSB +: 3] = exc.uncontainable ? ERR_TYPE_UNCONTAINABLE
					: ERR_TYPE_UNRECOVERABLE;
				hyp_detail[EXT_ABORT_BIT] = 1'b0;
			end
			EXC_DATA_ABORT, EXC_DATA_ABORT_NO_ISV: begin
				hyp_detail[EXT_ABORT_BIT] = 1'b0;
			end
			default: begin
				hyp_detail = exc.detail;
			end
		endcase
	end

	always_comb begin
		case (exc.kind)
			EXC_PHYS_SYSERR, EXC_VIRT_SYSERR, EXC_INSTR_ABORT, EXC_MISALIGNED,
			EXC_DATA_ABORT_NO_ISV, EXC_ILLEGAL_STATE: begin
				top_long = 1'b1;
			end
			default: begin
				top_long = exc.length_32 | (exc.exc_class == CLASS_UNKNOWN);
			end
		endcase
	end

	// The system error class passes its detail untouched; its coding is the core's own
	assign top_detail = exc.detail_valid ? exc.detail[23:0] : 24'h00_0000;

	always_comb begin
		hyp_syndrome_d = hyp_exception_syndrome_q;
		if (hyp_write_ok && req.sel == SEL_HYP_SYNDROME) begin
			hyp_syndrome_d = req.wdata[31:0];
		end
		// A report landing with a software write wins, so no exception is lost
		if (exc.valid && !exc.to_top && hyp_present_q) begin
			hyp_syndrome_d = {exc.exc_class, exc.length_32, hyp_detail};
		end
	end

	always_comb begin
		top_syndrome_d = top_exception_syndrome_q;
		if (sw_write && req.sel == SEL_TOP_SYNDROME) begin
			top_syndrome_d = req.wdata[31:0];
			if (!req.wdata[SYND_VALID_BIT]) begin
				top_syndrome_d[23:0] = 24'h00_0000;
			end
		end
		if (exc.valid && exc.to_top) begin
			top_syndrome_d = {exc.exc_class, top_long, exc.detail_valid, top_detail};
		end
	end

	always_comb begin
		config_d = hyp_configuration_q;
		if (hyp_write_ok && req.sel == SEL_HYP_CONFIG) begin
			config_d = (req.wdata & ~CFG_ZERO_MASK) | CFG_ONE_MASK;
		end
	end

	// Writable state has no architected reset; zero (configuration bit 31 one) is chosen only to keep simulation clean
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hyp_exception_syndrome_q <= SYNDROME_RESET;
		end else begin
			hyp_exception_syndrome_q <= hyp_syndrome_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			top_exception_syndrome_q <= SYNDROME_RESET;
		end else begin
			top_exception_syndrome_q <= top_syndrome_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hyp_configuration_q <= CONFIG_RESET;
		end else begin
			hyp_configuration_q <= config_d;
		end
	end

	// ****************************************
	// Trap general exceptions and routing
	// ****************************************
	logic trap_general_live;

	// Taken from the register every cycle; nothing downstream may hold a copy
	assign trap_general_live = hyp_configuration_q[CFG_TRAP_GENERAL] & nonsecure_state_bit;

	always_comb begin
		routing.route_kernel_to_hyp = trap_general_live;
		routing.kernel_translation_enable = kernel_translation_enable & ~trap_general_live;
		routing.fast_irq_route = hyp_configuration_q[CFG_FAST_IRQ_ROUTE] | trap_general_live;
		routing.irq_route = hyp_configuration_q[CFG_IRQ_ROUTE] | trap_general_live;
		routing.async_abort_route = hyp_configuration_q[CFG_ASYNC_ABORT_ROUTE] | trap_general_live;
		routing.virtual_irq_enable = ~trap_general_live;
		routing.impl_virtual_signal_enable = ~trap_general_live;
		routing.illegal_return = eret_to_kernel & trap_general_live;
	end

	// ****************************************
	// Read path
	// ****************************************
	logic is_id_group3;
	logic read_trap;
	logic [63:0] read_value;

	assign is_id_group3 = (req.sel >= SEL_DEBUG_FEATURE_ZERO) && (req.sel <= SEL_ISA_ATTRIBUTE_ZERO);
	assign read_trap = req.valid & ~req.write & is_id_group3 & req.nonsecure & (req.level == LEVEL_KERNEL)
		& hyp_configuration_q[CFG_ID_GROUP3_TRAP];

	always_comb begin
		case (req.sel)
			SEL_HYP_SYNDROME: begin
				read_value = hyp_present_q ? {32'h0000_0000, hyp_exception_syndrome_q} : 64'h0;
			end
			SEL_TOP_SYNDROME: begin
				read_value = {32'h0000_0000, top_exception_syndrome_q};
			end
			SEL_HYP_CONFIG: begin
				read_value = hyp_present_q ? hyp_configuration_q : 64'h0;
			end
			SEL_DEBUG_FEATURE_ZERO: begin
				read_value = DEBUG_FEATURE_ZERO_VALUE;
			end
			SEL_ISA_ATTRIBUTE_ZERO: begin
				read_value = ISA_ATTRIBUTE_ZERO_VALUE;
			end
			SEL_DEBUG_FEATURE_ONE, SEL_AUX_FEATURE_ZERO, SEL_AUX_FEATURE_ONE: begin
				read_value = ZERO_FEATURE_VALUE;
			end
			default: begin
				read_value = 64'h0;
			end
		endcase
	end

	// One response per request, a cycle after it is taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp <= '0;
		end else begin
			rsp.valid <= req.valid;
			rsp.trap <= read_trap;
			rsp.rdata <= (req.valid && !req.write && !read_trap) ? read_value : 64'h0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_hyp_virtual_syndrome:
	assert property (@(posedge clk) disable iff (!rst_n)
		exc.valid && !exc.to_top && hyp_present_q && exc.kind == EXC_VIRT_SYSERR
		|=> hyp_exception_syndrome_q[24:0] == $past(virtual_syserr_syndrome))
		else $error("virtual system error syndrome not copied");

	a_phys_syserr_fields:
	assert property (@(posedge clk) disable iff (!rst_n)
		exc.valid && !exc.to_top && hyp_present_q && exc.kind == EXC_PHYS_SYSERR
		|=> !hyp_exception_syndrome_q[IMPL_SYND_BIT] && !hyp_exception_syndrome_q[EXT_ABORT_BIT]
		&& hyp_exception_syndrome_q[ERR_TYPE_LSB +: 3] == ($past(exc.uncontainable) ? 3'h0 : 3'h1))
		else $error("physical system error syndrome malformed");

	a_dabort_no_ext:
	assert property (@(posedge clk) disable iff (!rst_n)
		exc.valid && !exc.to_top && hyp_present_q && exc.kind == EXC_DATA_ABORT
		|=> !hyp_exception_syndrome_q[EXT_ABORT_BIT])
		else $error("data abort reported external abort");

	a_absent_hyp_zero:
	assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && !hyp_present_q
		&& (req.sel == SEL_HYP_SYNDROME || req.sel == SEL_HYP_CONFIG)
		|=> rsp.valid && rsp.rdata == 64'h0)
		else $error("hypervisor register visible without hypervisor level");

	a_top_length_forced:
	assert property (@(posedge clk) disable iff (!rst_n)
		exc.valid && exc.to_top && (exc.kind == EXC_INSTR_ABORT || exc.exc_class == CLASS_UNKNOWN)
		|=> top_exception_syndrome_q[LENGTH_BIT])
		else $error("top syndrome length flag not forced");

	a_top_invalid_detail:
	assert property (@(posedge clk) disable iff (!rst_n)
		!top_exception_syndrome_q[SYND_VALID_BIT] && $past(exc.valid && exc.to_top)
		|-> top_exception_syndrome_q[23:0] == 24'h00_0000)
		else $error("invalid top syndrome has nonzero detail");

	a_config_fixed_bits:
	assert property (@(posedge clk) disable iff (!rst_n)
		hyp_configuration_q[31] && ((hyp_configuration_q & CFG_ZERO_MASK) == 64'h0))
		else $error("configuration fixed bits wrong");

	a_trap_general_routes:
	assert property (@(posedge clk) disable iff (!rst_n)
		hyp_configuration_q[CFG_TRAP_GENERAL] && nonsecure_state_bit
		|-> routing.route_kernel_to_hyp && !routing.kernel_translation_enable
		&& routing.fast_irq_route && routing.irq_route && routing.async_abort_route
		&& !routing.virtual_irq_enable)
		else $error("trap general not applied");

	a_secure_ignores_tge:
	assert property (@(posedge clk) disable iff (!rst_n)
		!nonsecure_state_bit |-> !routing.route_kernel_to_hyp && !routing.illegal_return
		&& routing.kernel_translation_enable == kernel_translation_enable)
		else $error("trap general acted in secure state");

	a_illegal_return:
	assert property (@(posedge clk) disable iff (!rst_n)
		routing.illegal_return == (eret_to_kernel && hyp_configuration_q[CFG_TRAP_GENERAL]
		&& nonsecure_state_bit))
		else $error("kernel return legality wrong");

	a_group3_trap:
	assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && req.sel == SEL_ISA_ATTRIBUTE_ZERO && req.nonsecure
		&& req.level == LEVEL_KERNEL
		|=> rsp.trap == $past(hyp_configuration_q[CFG_ID_GROUP3_TRAP]))
		else $error("group-3 trap decision wrong");

	a_debug_feature_value:
	assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && req.sel == SEL_DEBUG_FEATURE_ZERO && !read_trap
		|=> rsp.rdata[31:28] == 4'h1 && rsp.rdata[23:20] == 4'h3 && rsp.rdata[15:12] == 4'h5
		&& rsp.rdata[11:8] == 4'h4 && rsp.rdata[3:0] == 4'h8)
		else $error("debug feature value wrong");

	a_isa_feature_value:
	assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && req.sel == SEL_ISA_ATTRIBUTE_ZERO && !read_trap
		|=> rsp.rdata[31:28] == 4'h1 && rsp.rdata[23:20] == 4'h2 && rsp.rdata[19:16] == 4'h1
		&& rsp.rdata[63:48] == 16'h0 && rsp.rdata[43:32] == 12'h0)
		else $error("instruction attribute value wrong");

	a_aux_reads_zero:
	assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && (req.sel == SEL_AUX_FEATURE_ZERO || req.sel == SEL_AUX_FEATURE_ONE
		|| req.sel == SEL_DEBUG_FEATURE_ONE)
		|=> rsp.rdata == 64'h0)
		else $error("reserved feature register nonzero");

	a_hyp_class_length:
	assert property (@(posedge clk) disable iff (!rst_n)
		exc.valid && !exc.to_top && hyp_present_q
		|=> hyp_exception_syndrome_q[31:26] == $past(exc.exc_class)
		&& hyp_exception_syndrome_q[LENGTH_BIT] == $past(exc.length_32))
		else $error("hypervisor syndrome class or length wrong");

	a_top_class_valid:
	assert property (@(posedge clk) disable iff (!rst_n)
		exc.valid && exc.to_top
		|=> top_exception_syndrome_q[31:26] == $past(exc.exc_class)
		&& top_exception_syndrome_q[SYND_VALID_BIT] == $past(exc.detail_valid))
		else $error("top syndrome class or valid flag wrong");

endmodule

/* File: tb/syndrome_hypconfig_feature_regs_tb_top.sv */
// Self-checking bench for the syndrome, configuration and feature register bank
`timescale 1ns/1ns
module syndrome_hypconfig_feature_regs_tb_top;
	import sysreg_bank_pkg::*;

	// ****************************************
	// Stimulus and observation signals
	// ****************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hyp_level_present = 1'b1;
	sysreg_req_t req = '0;
	sysreg_rsp_t rsp;
	exc_report_t exc = '0;
	logic [24:0] virtual_syserr_syndrome = 25'h0;
	logic nonsecure_state_bit = 1'b0;
	logic kernel_translation_enable = 1'b1;
	logic eret_to_kernel = 1'b1;
	routing_t routing;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [63:0] rd;
	logic tr;
	exc_kind_t forced_kinds [5] = '{EXC_MISALIGNED, EXC_DATA_ABORT_NO_ISV, EXC_ILLEGAL_STATE,
		EXC_PHYS_SYSERR, EXC_VIRT_SYSERR};

	always #50 clk = ~clk;

	syndrome_hypconfig_feature_regs u_dut (
		.clk(clk),
		.rst_n(rst_n),
		.hyp_level_present(hyp_level_present),
		.req(req),
		.rsp(rsp),
		.exc(exc),
		.virtual_syserr_syndrome(virtual_syserr_syndrome),
		.nonsecure_state_bit(nonsecure_state_bit),
		.kernel_translation_enable(kernel_translation_enable),
		.eret_to_kernel(eret_to_kernel),
		.routing(routing)
	);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Response is registered at the taking edge, so it is sampled on the next falling edge
	task automatic access(input logic wr, input logic [3:0] sel, input logic [1:0] lvl, input logic ns,
		input logic [63:0] wd, output logic [63:0] data, output logic trap);
		@(negedge clk);
		req.valid = 1'b1;
		req.write = wr;
		req.sel = sel;
		req.level = lvl;
		req.nonsecure = ns;
		req.wdata = wd;
		@(negedge clk);
		check("response valid", {63'h0, rsp.valid}, 64'h1);
		data = rsp.rdata;
		trap = rsp.trap;
		req.valid = 1'b0;
	endtask

	task automatic wr(input logic [3:0] sel, input logic [63:0] wd);
		logic [63:0] d;
		logic t;
		access(1'b1, sel, LEVEL_HYP, 1'b1, wd, d, t);
	endtask

	task automatic read_expect(input string what, input logic [3:0] sel, input logic [63:0] exp);
		access(1'b0, sel, LEVEL_HYP, 1'b1, 64'h0, rd, tr);
		check(what, rd, exp);
	endtask

	task automatic report(input logic top, input exc_kind_t kind, input logic [5:0] cls, input logic len,
		input logic dv, input logic unc, input logic [24:0] det);
		@(negedge clk);
		exc.valid = 1'b1;
		exc.to_top = top;
		exc.kind = kind;
		exc.exc_class = cls;
		exc.length_32 = len;
		exc.detail_valid = dv;
		exc.uncontainable = unc;
		exc.detail = det;
		@(negedge clk);
		exc.valid = 1'b0;
		access(1'b0, top ? SEL_TOP_SYNDROME : SEL_HYP_SYNDROME, LEVEL_TOP, 1'b0, 64'h0, rd, tr);
	endtask

	task automatic do_reset();
		@(negedge clk);
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
	endtask

	// ****************************************
	// Hang guard
	// ****************************************
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			$display("BAD cycle limit expected finish seen hang");
			summarize();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		read_expect("debug feature zero", SEL_DEBUG_FEATURE_ZERO, 64'h0000_0000_1030_5408);
		read_expect("isa attribute zero", SEL_ISA_ATTRIBUTE_ZERO, 64'h0000_0000_1021_0000);
		read_expect("debug feature one", SEL_DEBUG_FEATURE_ONE, 64'h0);
		read_expect("aux feature zero", SEL_AUX_FEATURE_ZERO, 64'h0);
		read_expect("aux feature one", SEL_AUX_FEATURE_ONE, 64'h0);
		read_expect("hyp aux config", SEL_HYP_AUX_CONFIG, 64'h0);
		read_expect("unmapped select", 4'h9, 64'h0);
		wr(SEL_DEBUG_FEATURE_ZERO, 64'hffff_ffff_ffff_ffff);
		read_expect("debug zero after write", SEL_DEBUG_FEATURE_ZERO, 64'h0000_0000_1030_5408);
		wr(SEL_HYP_CONFIG, 64'hffff_ffff_ffff_ffff);
		read_expect("config all ones", SEL_HYP_CONFIG, 64'h0000_007f_ffff_7fff);
		wr(SEL_HYP_CONFIG, 64'h0);
		read_expect("config cleared", SEL_HYP_CONFIG, 64'h0000_0000_8000_0000);
		// Trap general with routing bits clear, so forcing is visible
		wr(SEL_HYP_CONFIG, 64'h0000_0000_0800_0000);
		nonsecure_state_bit = 1'b1;
		#10;
		check("routing trap general", {56'h0, routing}, 64'hb9);
		// Inputs move only on falling edges; routing is combinational and settles in between
		@(negedge clk);
		eret_to_kernel = 1'b0;
		kernel_translation_enable = 1'b0;
		#10;
		check("routing no return", {56'h0, routing}, 64'hb8);
		@(negedge clk);
		nonsecure_state_bit = 1'b0;
		eret_to_kernel = 1'b1;
		kernel_translation_enable = 1'b1;
		#10;
		check("routing secure", {56'h0, routing}, 64'h46);
		wr(SEL_HYP_CONFIG, 64'h0000_0000_0004_0000);
		access(1'b0, SEL_ISA_ATTRIBUTE_ZERO, LEVEL_KERNEL, 1'b1, 64'h0, rd, tr);
		check("group3 trap flag", {63'h0, tr}, 64'h1);
		check("group3 trap data", rd, 64'h0);
		access(1'b0, SEL_DEBUG_FEATURE_ZERO, LEVEL_HYP, 1'b1, 64'h0, rd, tr);
		check("group3 hyp read", {tr, rd[62:0]}, 64'h0000_0000_1030_5408);
		wr(SEL_HYP_CONFIG, 64'h0);
		access(1'b0, SEL_AUX_FEATURE_ONE, LEVEL_KERNEL, 1'b1, 64'h0, rd, tr);
		check("group3 untrapped", {63'h0, tr}, 64'h0);
		// Hypervisor syndrome captures
		virtual_syserr_syndrome = 25'h1a5_a5a5;
		report(1'b0, EXC_VIRT_SYSERR, 6'h2f, 1'b1, 1'b0, 1'b0, 25'h0);
		check("virtual syserr detail", {39'h0, rd[24:0]}, 64'h1a5_a5a5);
		check("syndrome upper word", {32'h0, rd[63:32]}, 64'h0);
		report(1'b0, EXC_PHYS_SYSERR, 6'h2f, 1'b1, 1'b0, 1'b1, 25'h1ff_ffff);
		check("phys syserr uncontainable", {59'h0, rd[24], rd[12:10], rd[9]}, 64'h00);
		report(1'b0, EXC_PHYS_SYSERR, 6'h2f, 1'b1, 1'b0, 1'b0, 25'h1ff_ffff);
		check("phys syserr unrecoverable", {59'h0, rd[24], rd[12:10], rd[9]}, 64'h02);
		report(1'b0, EXC_DATA_ABORT, 6'h24, 1'b1, 1'b0, 1'b0, 25'h000_0200);
		check("data abort ext abort", {57'h0, rd[31:26], rd[9]}, 64'h48);
		report(1'b0, EXC_OTHER, 6'h15, 1'b0, 1'b0, 1'b0, 25'h000_1234);
		check("hyp short instruction", rd, 64'h5400_1234);
		wr(SEL_HYP_SYNDROME, 64'hffff_ffff_1234_5678);
		read_expect("hyp syndrome write", SEL_HYP_SYNDROME, 64'h1234_5678);
		wr(SEL_TOP_SYNDROME, 64'h0000_0000_02ff_ffff);
		read_expect("top write invalid", SEL_TOP_SYNDROME, 64'h0200_0000);
		// Top syndrome captures
		report(1'b1, EXC_INSTR_ABORT, 6'h20, 1'b0, 1'b1, 1'b0, 25'h0ab_cdef);
		check("top instr abort", rd, 64'h83ab_cdef);
		report(1'b1, EXC_OTHER, 6'h00, 1'b0, 1'b0, 1'b0, 25'h0ff_ffff);
		check("top class zero invalid", rd, 64'h0200_0000);
		report(1'b1, EXC_OTHER, 6'h2f, 1'b1, 1'b1, 1'b0, 25'h012_3456);
		check("top syserr class", rd, 64'hbf12_3456);
		report(1'b1, EXC_OTHER, 6'h15, 1'b0, 1'b1, 1'b0, 25'h000_0077);
		check("top short instruction", rd, 64'h5500_0077);
		foreach (forced_kinds[i]) begin
			report(1'b1, forced_kinds[i], 6'h15, 1'b0, 1'b1, 1'b0, 25'h0);
			check("top forced length", {63'h0, rd[25]}, 64'h1);
		end
		// Without the hypervisor level its registers read zero and ignore writes
		hyp_level_present = 1'b0;
		do_reset();
		wr(SEL_HYP_CONFIG, 64'h0000_0000_0800_0000);
		read_expect("config absent level", SEL_HYP_CONFIG, 64'h0);
		// The swallowed write set trap general; routing would show it had it landed
		nonsecure_state_bit = 1'b1;
		#10;
		check("absent write ignored", {63'h0, routing.route_kernel_to_hyp}, 64'h0);
		report(1'b0, EXC_OTHER, 6'h15, 1'b1, 1'b0, 1'b0, 25'h000_0011);
		check("hyp syndrome absent level", rd, 64'h0);
		summarize();
	end
endmodule
